// ==== hdl/lpc_pkg.sv ====
// Constants for the line power configuration register bank
package lpc_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_IMPEDANCE = 8'h0a;
  localparam logic [7:0] IDX_HYBRID    = 8'h0b;
  localparam logic [7:0] IDX_POWER_A   = 8'h0e;
  localparam logic [7:0] IDX_POWER_B   = 8'h0f;
  // Writable bit masks, reserved positions zero
  localparam logic [7:0] MASK_IMPEDANCE = 8'h3f;
  localparam logic [7:0] MASK_HYBRID    = 8'h77;
  localparam logic [7:0] MASK_POWER_A   = 8'h1b;
  localparam logic [7:0] MASK_POWER_B   = 8'h3f;
  // Reset values
  localparam logic [7:0] RST_IMPEDANCE = 8'h00;
  localparam logic [7:0] RST_HYBRID    = 8'h33;
  localparam logic [7:0] RST_POWER_A   = 8'h00;
  localparam logic [7:0] RST_POWER_B   = 8'h00;
  // Field positions
  localparam int unsigned POS_CAP_COMP  = 4;
  localparam int unsigned POS_SYNTH_EN  = 3;
  localparam int unsigned POS_SYNTH_SEL = 0;
  localparam int unsigned POS_METER_HYB = 4;
  localparam int unsigned POS_AUDIO_HYB = 0;
  localparam int unsigned POS_CONV_OFF  = 4;
  localparam int unsigned POS_PLL_FREE  = 3;
  localparam int unsigned POS_BIAS_OFF  = 1;
  localparam int unsigned POS_LINE_OFF  = 0;
  localparam int unsigned POS_ADC_MAN   = 5;
  localparam int unsigned POS_ADC_ON    = 4;
  localparam int unsigned POS_DAC_MAN   = 3;
  localparam int unsigned POS_DAC_ON    = 2;
  localparam int unsigned POS_GM_MAN    = 1;
  localparam int unsigned POS_GM_ON     = 0;
  // Encodings
  localparam logic [1:0] CAP_OFF      = 2'h0;
  localparam logic [1:0] CAP_4N7      = 2'h1;
  localparam logic [1:0] CAP_10N      = 2'h2;
  localparam logic [2:0] HYB_OFF_CODE = 3'h7;
  localparam logic [2:0] HYB_0DB_CODE = 3'h3;
endpackage : lpc_pkg

// ==== hdl/lpc_power_sel.sv ====
// Manual or automatic selection of one power enable
module lpc_power_sel
(
  input  wire logic manual,
  input  wire logic manual_on,
  input  wire logic auto_on,
  output logic      power_on
);
  // Manual on bit only counts while manual mode is set
  always_comb
  begin
    power_on = manual ? manual_on : auto_on;
  end
endmodule : lpc_power_sel

// ==== hdl/lpc_regs.sv ====
// Line power configuration register bank with Wishbone slave
// Operation
// - Cap compensation: off, 4.7nF, 10nF, reserved
// - Bit 3 enables two-wire impedance synthesis
// - Bits 2:0 pick one of eight terminations
// - Hybrid gains share one code; 111 is off
// - Hybrid register resets to 0x33, both 0dB
// - Bit 4 forces dc-dc converter off
// - Bit 3 forces PLL into free-run
// - Bit 1 forces dc bias off
// - Bit 0 forces line interface off
// - ADC manual bit gates ADC on bit
// - DAC manual bit gates DAC on bit
// - Amplifier manual bit gates its on bit
module lpc_regs
(
  input  wire logic        clk_sys,
  input  wire logic        nrst,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic             wb_err_o,
  input  wire logic        auto_converter_on,
  input  wire logic        auto_pll_freerun,
  input  wire logic        auto_bias_on,
  input  wire logic        auto_line_iface_on,
  input  wire logic        auto_adc_on,
  input  wire logic        auto_dac_on,
  input  wire logic        auto_transcond_on,
  output logic      [1:0]  line_cap_comp,
  output logic             cap_comp_active,
  output logic             impedance_synth_en,
  output logic      [2:0]  impedance_synth_sel,
  output logic      [2:0]  metering_hybrid_adj,
  output logic             metering_hybrid_on,
  output logic      [2:0]  audio_hybrid_adj,
  output logic             audio_hybrid_on,
  output logic             converter_power_on,
  output logic             pll_freerun,
  output logic             bias_power_on,
  output logic             line_iface_power_on,
  output logic             adc_power,
  output logic             dac_power,
  output logic             transcond_amp_power
);
  logic [7:0]  impedance_reg;
  logic [7:0]  impedance_next;
  logic [7:0]  hybrid_reg;
  logic [7:0]  hybrid_next;
  logic [7:0]  power_a_reg;
  logic [7:0]  power_a_next;
  logic [7:0]  power_b_reg;
  logic [7:0]  power_b_next;
  logic        ack_reg;
  logic        ack_next;
  logic        err_reg;
  logic        err_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic        req;
  logic        hit;
  logic        wr_lane;
  logic [7:0]  idx;
  logic [7:0]  rd_byte;
  logic [7:0]  wbyte;
  logic        adc_pwr;
  logic        dac_pwr;
  logic        gm_pwr;
  logic        wr_commit;
  logic        wr_imp;
  logic        wr_hyb;
  logic        wr_pa;
  logic        wr_pb;

  // New request only when no answer is pending, so ack drops after one cycle
  assign req     = wb_cyc_i && wb_stb_i && !ack_reg && !err_reg;
  assign idx     = {2'h0, wb_adr_i[7:2]};
  assign wr_lane = wb_sel_i[0];
  assign wbyte   = wb_dat_i[7:0];

  always_comb
  begin
    hit     = 1'b1;
    rd_byte = 8'h00;
    unique case (idx)
      lpc_pkg::IDX_IMPEDANCE: rd_byte = impedance_reg;
      lpc_pkg::IDX_HYBRID:    rd_byte = hybrid_reg;
      lpc_pkg::IDX_POWER_A:   rd_byte = power_a_reg;
      lpc_pkg::IDX_POWER_B:   rd_byte = power_b_reg;
      default:                hit     = 1'b0;
    endcase
  end

  // Commit only at the acknowledged edge, so a dropped cycle writes nothing
  assign wr_commit = ack_reg && wb_cyc_i && wb_stb_i && wb_we_i && wr_lane;

  // One write strobe per register
  always_comb
  begin
    wr_imp = 1'h0;
    wr_hyb = 1'h0;
    wr_pa  = 1'h0;
    wr_pb  = 1'h0;
    if (wr_commit)
    begin
      // Ack implies a hit; an index changed under ack to an unmapped one writes nothing
      unique case (idx)
        lpc_pkg::IDX_IMPEDANCE: wr_imp = 1'h1;
        lpc_pkg::IDX_HYBRID:    wr_hyb = 1'h1;
        lpc_pkg::IDX_POWER_A:   wr_pa  = 1'h1;
        lpc_pkg::IDX_POWER_B:   wr_pb  = 1'h1;
        default:                wr_pb  = 1'h0;
      endcase
    end
  end

  // Bus answer; one registered ack or err per taken request
  always_comb
  begin
    ack_next   = 1'h0;
    err_next   = 1'h0;
    rdata_next = rdata_reg;
    if (req)
    begin
      ack_next = hit;
      err_next = !hit;
      // Writes and errors return zero so stale data never leaks
      if (!wb_we_i && hit)
      begin
        rdata_next = {24'h000000, rd_byte};
      end
      else
      begin
        rdata_next = 32'h00000000;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      ack_reg   <= 1'h0;
      err_reg   <= 1'h0;
      rdata_reg <= 32'h00000000;
    end
    else
    begin
      ack_reg   <= ack_next;
      err_reg   <= err_next;
      rdata_reg <= rdata_next;
    end
  end

  // Impedance group; reserved positions masked so they never read back
  always_comb
  begin
    impedance_next = impedance_reg;
    if (wr_imp)
    begin
      impedance_next = wbyte & lpc_pkg::MASK_IMPEDANCE;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      impedance_reg <= lpc_pkg::RST_IMPEDANCE;
    end
    else
    begin
      impedance_reg <= impedance_next;
    end
  end

  // Hybrid group
  always_comb
  begin
    hybrid_next = hybrid_reg;
    if (wr_hyb)
    begin
      hybrid_next = wbyte & lpc_pkg::MASK_HYBRID;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      // Both gains start at the 0 dB code
      hybrid_reg <= lpc_pkg::RST_HYBRID;
    end
    else
    begin
      hybrid_reg <= hybrid_next;
    end
  end

  // Override group; automatic control decides while a bit is clear
  always_comb
  begin
    power_a_next = power_a_reg;
    if (wr_pa)
    begin
      power_a_next = wbyte & lpc_pkg::MASK_POWER_A;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      power_a_reg <= lpc_pkg::RST_POWER_A;
    end
    else
    begin
      power_a_reg <= power_a_next;
    end
  end

  // Manual power group
  always_comb
  begin
    power_b_next = power_b_reg;
    if (wr_pb)
    begin
      power_b_next = wbyte & lpc_pkg::MASK_POWER_B;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      power_b_reg <= lpc_pkg::RST_POWER_B;
    end
    else
    begin
      power_b_reg <= power_b_next;
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_err_o = err_reg;
  assign wb_dat_o = rdata_reg;

  // Field decode straight from flops, so outputs are glitch free
  assign line_cap_comp   = impedance_reg[lpc_pkg::POS_CAP_COMP +: 2];
  // Reserved code 11 treated as no compensation
  assign cap_comp_active = (line_cap_comp == lpc_pkg::CAP_4N7) ||
                           (line_cap_comp == lpc_pkg::CAP_10N);
  assign impedance_synth_en  = impedance_reg[lpc_pkg::POS_SYNTH_EN];
  assign impedance_synth_sel =
    impedance_reg[lpc_pkg::POS_SYNTH_SEL +: 3];
  assign metering_hybrid_adj = hybrid_reg[lpc_pkg::POS_METER_HYB +: 3];
  assign audio_hybrid_adj    = hybrid_reg[lpc_pkg::POS_AUDIO_HYB +: 3];
  assign metering_hybrid_on  =
    metering_hybrid_adj != lpc_pkg::HYB_OFF_CODE;
  assign audio_hybrid_on     =
    audio_hybrid_adj != lpc_pkg::HYB_OFF_CODE;

  assign converter_power_on  = auto_converter_on &&
                               !power_a_reg[lpc_pkg::POS_CONV_OFF];
  assign pll_freerun         = auto_pll_freerun ||
                               power_a_reg[lpc_pkg::POS_PLL_FREE];
  assign bias_power_on       = auto_bias_on &&
                               !power_a_reg[lpc_pkg::POS_BIAS_OFF];
  assign line_iface_power_on = auto_line_iface_on &&
                               !power_a_reg[lpc_pkg::POS_LINE_OFF];

  lpc_power_sel u_adc_sel
  (
    .manual    (power_b_reg[lpc_pkg::POS_ADC_MAN]),
    .manual_on (power_b_reg[lpc_pkg::POS_ADC_ON]),
    .auto_on   (auto_adc_on),
    .power_on  (adc_pwr)
  );

  lpc_power_sel u_dac_sel
  (
    .manual    (power_b_reg[lpc_pkg::POS_DAC_MAN]),
    .manual_on (power_b_reg[lpc_pkg::POS_DAC_ON]),
    .auto_on   (auto_dac_on),
    .power_on  (dac_pwr)
  );

  lpc_power_sel u_gm_sel
  (
    .manual    (power_b_reg[lpc_pkg::POS_GM_MAN]),
    .manual_on (power_b_reg[lpc_pkg::POS_GM_ON]),
    .auto_on   (auto_transcond_on),
    .power_on  (gm_pwr)
  );

  assign adc_power           = adc_pwr;
  assign dac_power           = dac_pwr;
  assign transcond_amp_power = gm_pwr;
endmodule : lpc_regs

// ==== verification/lpc_regs_chk.sv ====
// Assertion checker for the line power configuration registers
module lpc_regs_chk
(
  input wire logic       clk_sys,
  input wire logic       nrst,
  input wire logic       wb_ack_o,
  input wire logic       auto_converter_on,
  input wire logic       auto_pll_freerun,
  input wire logic       auto_bias_on,
  input wire logic       auto_line_iface_on,
  input wire logic [1:0] line_cap_comp,
  input wire logic       cap_comp_active,
  input wire logic       impedance_synth_en,
  input wire logic [2:0] impedance_synth_sel,
  input wire logic [2:0] metering_hybrid_adj,
  input wire logic       metering_hybrid_on,
  input wire logic [2:0] audio_hybrid_adj,
  input wire logic       audio_hybrid_on,
  input wire logic       converter_power_on,
  input wire logic       pll_freerun,
  input wire logic       bias_power_on,
  input wire logic       line_iface_power_on
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  // Code 11 is reserved, so only 01 and 10 count as active
  chk_cap_active: assert property (
    cap_comp_active == ^line_cap_comp)
    else $error("cap compensation active flag wrong");
  chk_meter_on: assert property (
    metering_hybrid_on == (metering_hybrid_adj != 3'h7))
    else $error("metering hybrid on flag wrong");
  chk_audio_on: assert property (
    audio_hybrid_on == (audio_hybrid_adj != 3'h7))
    else $error("audio hybrid on flag wrong");
  chk_hyb_reset: assert property (
    $rose(nrst) |-> {metering_hybrid_adj, audio_hybrid_adj} == 6'h1b)
    else $error("hybrid fields not 0 dB after reset");
  // Fields move only at the edge that samples ack high
  chk_field_hold: assert property (
    $changed({line_cap_comp, impedance_synth_en, impedance_synth_sel,
      metering_hybrid_adj, audio_hybrid_adj}) |-> $past(wb_ack_o))
    else $error("field changed without a bus cycle");
  chk_conv_off: assert property (
    !auto_converter_on |-> !converter_power_on)
    else $error("converter on without automatic request");
  chk_pll_force: assert property (
    auto_pll_freerun |-> pll_freerun)
    else $error("automatic free-run not honoured");
  chk_bias_off: assert property (
    !auto_bias_on |-> !bias_power_on)
    else $error("bias on without automatic request");
  chk_line_off: assert property (
    !auto_line_iface_on |-> !line_iface_power_on)
    else $error("line interface on without automatic request");
endmodule : lpc_regs_chk

bind lpc_regs lpc_regs_chk u_chk (.*);

// ==== verification/testbench.sv ====
// Self-checking bench for the line power configuration registers
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys = 1'b0, nrst = 1'b0;
  logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [3:0]  wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
  logic        auto_converter_on = 1'b0, auto_pll_freerun = 1'b0;
  logic        auto_bias_on = 1'b0, auto_line_iface_on = 1'b0;
  logic        auto_adc_on = 1'b0, auto_dac_on = 1'b0;
  logic        auto_transcond_on = 1'b0;
  logic        wb_ack_o, wb_err_o, cap_comp_active, impedance_synth_en;
  logic [1:0]  line_cap_comp;
  logic [2:0]  impedance_synth_sel, metering_hybrid_adj, audio_hybrid_adj;
  logic        metering_hybrid_on, audio_hybrid_on, converter_power_on;
  logic        pll_freerun, bias_power_on, line_iface_power_on;
  logic        adc_power, dac_power, transcond_amp_power;
  logic [7:0]  adr_t [4] = '{8'h28, 8'h2c, 8'h38, 8'h3c};
  logic [7:0]  rst_t [4] = '{8'h00, 8'h33, 8'h00, 8'h00};
  logic [7:0]  msk_t [4] = '{8'h3f, 8'h77, 8'h1b, 8'h3f};
  int          n_errors = 0, n_checks = 0;
  lpc_regs u_dut (.*);
  always #2.5 clk_sys = ~clk_sys;

  task automatic complete_run();
    if (n_errors == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : complete_run

  task automatic check(string what, logic [31:0] exp, logic [31:0] got);
    n_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // One classic cycle; request held until the edge that samples ack
  task automatic xfer(logic we, logic [7:0] adr, logic [7:0] wd,
                      logic [3:0] sel, logic [31:0] rd, logic err);
    @(posedge clk_sys);
    {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'h3, we};
    {wb_adr_i, wb_sel_i, wb_dat_i} <= {adr, sel, 24'h0, wd};
    do
    begin
      @(posedge clk_sys);
    end
    while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1);
    check("resp", {30'h0, err, !err}, {30'h0, wb_err_o, wb_ack_o});
    if (!we && !err)
      check("rdata", rd, wb_dat_o);
    {wb_cyc_i, wb_stb_i} <= 2'h0;
    // Writes land at the ack edge; outputs are read one edge later
    @(posedge clk_sys);
  endtask : xfer

  initial
  begin
    repeat (16) @(posedge clk_sys);
    nrst <= 1'b1;
    for (int i = 0; i < 4; i++)
      xfer(1'b0, adr_t[i], 8'h00, 4'h1, {24'h0, rst_t[i]}, 1'b0);
    for (int i = 0; i < 4; i++)
    begin
      xfer(1'b1, adr_t[i], 8'hff, 4'hf, 32'h0, 1'b0);
      xfer(1'b0, adr_t[i], 8'h00, 4'h1, {24'h0, msk_t[i]}, 1'b0);
    end
    // Disabled low byte and unmapped index must leave the bank alone
    xfer(1'b1, 8'h2c, 8'h00, 4'h0, 32'h0, 1'b0);
    xfer(1'b1, 8'h30, 8'h00, 4'h1, 32'h0, 1'b1);
    xfer(1'b0, 8'h2c, 8'h00, 4'h1, 32'h77, 1'b0);
    for (int i = 0; i < 64; i++)
    begin
      xfer(1'b1, 8'h28, 8'hc0 | 8'(i), 4'h1, 32'h0, 1'b0);
      check("imp", {i[5:4], ^i[5:4], i[3:0]},
            {line_cap_comp, cap_comp_active, impedance_synth_en,
             impedance_synth_sel});
      xfer(1'b1, 8'h2c, {1'b1, i[5:3], 1'b1, i[2:0]},
           4'h1, 32'h0, 1'b0);
      check("hyb",
            {i[5:3], i[5:3] != 3'h7, i[2:0], i[2:0] != 3'h7},
            {metering_hybrid_adj, metering_hybrid_on, audio_hybrid_adj,
             audio_hybrid_on});
    end
    for (int i = 0; i < 128; i++)
    begin
      {auto_converter_on, auto_pll_freerun, auto_bias_on} <= {3{i[6]}};
      {auto_line_iface_on, auto_adc_on} <= {2{i[6]}};
      {auto_dac_on, auto_transcond_on} <= {2{i[6]}};
      xfer(1'b1, 8'h38, 8'hc0 | 8'(i), 4'h1, 32'h0, 1'b0);
      xfer(1'b1, 8'h3c, 8'hc0 | 8'(i), 4'h1, 32'h0, 1'b0);
      check("pwra",
            {i[6] & !i[4], i[6] | i[3], i[6] & !i[1], i[6] & !i[0]},
            {converter_power_on, pll_freerun, bias_power_on,
             line_iface_power_on});
      check("pwrb",
            {i[5] ? i[4] : i[6], i[3] ? i[2] : i[6], i[1] ? i[0] : i[6]},
            {adc_power, dac_power, transcond_amp_power});
    end
    complete_run();
  end

  initial
  begin
    repeat (5000) @(posedge clk_sys);
    n_errors++;
    complete_run();
  end
endmodule : testbench
